// ### dqtx_tx_port.sv
// Transmit port: modulator, burst sequencing, DAC bypass and sleep control.
// How it works
// - Serial bits pair into X then Y dibits.
// - Dibit picks phase step added to previous phase.
// - Impulses lie on eight points pi/4 apart.
// - RRC shaping, span four symbols each side, 10-bit samples.
// - Leaving sleep runs calibration, then ready rises.
// - Source raises burst only while ready high.
// - Burst start sends three zero dibits, ramping up.
// - Ready drops next edge (here three edges after burst_in, two of them input sync); strobe three cycles later.
// - Source changes on strobe rise; port samples on fall.
// - After burst falls, finish dibit, eight flush strobes.
// - Ramp-down reaches zero after three symbols.
// - After last flush strobe, ready rises again.
// - Power request sampled on clock rising edges.
// - Power low sleeps with outputs undriven.
// - Two mode pins select one of four modes.
// - Bypass turns strobe, data, burst pins into inputs.
// - Source raises word sync one cycle before MSBs.
// - Bypass captures MSB first, keeps top ten bits.
// - Source sends a word pair every sixteen cycles.
// - Tone test holds I zero, Q full, keeps ramps.
// - Source never selects factory test mode.
// - Bit strobe is master clock over sixty-four.
// - Burst out follows the shaped output envelope.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dqtx_defines.svh"
module dqtx_tx_port
  import dqtx_pkg::*;
(
  input logic clk,
  input logic reset,
  dqtx_link_if.dev link,
  output logic [9:0] inphase_out,
  output logic [9:0] quadrature_out,
  output logic out_enable
);
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  logic power_s;
  dqtx_mode_t mode_s;
  logic burst_s;
  logic data_s;
  logic frame_s;
  logic burst_prev_r;
  dqtx_state_t state_r;
  dqtx_state_t state_nxt;
  logic [9:0] cal_cnt_r;
  logic [1:0] start_cnt_r;
  logic [5:0] bit_cnt_r;
  logic bit_half_r;
  logic stop_seen_r;
  logic [2:0] flush_cnt_r;
  logic x_r;
  logic y_r;
  logic [1:0] dly_r [0:`DQTX_ZERO_LINE-1];
  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic [4:0] gain_idx_r;
  logic [8:0] gain;
  logic active;
  logic sym_end;
  logic sample_en;
  logic start_go;
  logic signed [9:0] lvl_i;
  logic signed [9:0] lvl_q;
  logic signed [9:0] fir_i;
  logic signed [9:0] fir_q;
  logic byp_on_r;
  logic [3:0] byp_cnt_r;
  logic [14:0] sreg_i_r;
  logic [14:0] sreg_q_r;
  logic [9:0] byp_i_r;
  logic [9:0] byp_q_r;
  logic ready_r;
  logic burst_out_r;

  function automatic logic [2:0] step_of(input logic [1:0] xy);
    unique case (xy)
      2'b11: step_of = 3'h5;
      2'b01: step_of = 3'h3;
      2'b00: step_of = 3'h1;
      2'b10: step_of = 3'h7;
    endcase
  endfunction : step_of

  function automatic logic signed [9:0] cos_of(input logic [2:0] p);
    unique case (p)
      3'h0: cos_of = `DQTX_AMP_FULL;
      3'h1, 3'h7: cos_of = `DQTX_AMP_DIAG;
      3'h2, 3'h6: cos_of = 10'sd0;
      3'h3, 3'h5: cos_of = -$signed(`DQTX_AMP_DIAG);
      3'h4: cos_of = -$signed(`DQTX_AMP_FULL);
    endcase
  endfunction : cos_of

  // Every pin from the source crosses in through two flip-flops.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_r <= 6'h00;
      pin_sync_r <= 6'h00;
    end else begin
      pin_meta_r <= {link.power_req, link.mode_select_hi, link.mode_select_lo,
                     link.burst_in, link.serial_tx_bits, link.bit_strobe};
      pin_sync_r <= pin_meta_r;
    end
  end
  assign power_s = pin_sync_r[5];
  assign mode_s = dqtx_mode_t'(pin_sync_r[4:3]);
  assign burst_s = pin_sync_r[2];
  assign data_s = pin_sync_r[1];
  assign frame_s = pin_sync_r[0];

  assign active = (state_r == ST_RUN) || (state_r == ST_FLUSH);
  assign sym_end = active && bit_half_r && (bit_cnt_r == `DQTX_BIT_LAST);
  assign sample_en = active && (bit_cnt_r[3:0] == `DQTX_SAMPLE_LAST);
  assign start_go = (state_r == ST_IDLE) && burst_s && !burst_prev_r &&
                    ((mode_s == DQTX_MODULATOR) || (mode_s == DQTX_TONE_TEST));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_SLEEP: if (power_s) state_nxt = ST_CAL;
      ST_CAL: if (cal_cnt_r == `DQTX_CAL_CYCLES - 10'h001) state_nxt = ST_IDLE;
      ST_IDLE: if (start_go) state_nxt = ST_START;
      ST_START: if (start_cnt_r == `DQTX_STROBE_DELAY - 2'h1) state_nxt = ST_RUN;
      ST_RUN: if (sym_end && (stop_seen_r || !burst_s)) state_nxt = ST_FLUSH;
      ST_FLUSH: if (sym_end && flush_cnt_r == 3'h1) state_nxt = ST_IDLE;
    endcase
    if (!power_s) begin
      state_nxt = ST_SLEEP;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_SLEEP;
      burst_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      burst_prev_r <= burst_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_r != ST_CAL) begin
      cal_cnt_r <= 10'h000;
    end else begin
      cal_cnt_r <= cal_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_r != ST_START) begin
      start_cnt_r <= 2'h0;
    end else begin
      start_cnt_r <= start_cnt_r + 2'h1;
    end
  end

  // The strobe period is a plain divide of the master clock.
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      bit_cnt_r <= 6'h00;
      bit_half_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
      if (bit_cnt_r == `DQTX_BIT_LAST) begin
        bit_half_r <= !bit_half_r;
      end
    end
  end
  assign link.dev_strobe_o = active && (bit_cnt_r < `DQTX_HALF_CNT);
  // The strobe pin is only ours outside bypass; sleeping releases it too.
  assign link.dev_strobe_oe = (state_r != ST_SLEEP) && (mode_s != DQTX_BYPASS);

  always_ff @(posedge clk) begin
    if (reset || state_r != ST_RUN) begin
      stop_seen_r <= 1'b0;
    end else if (!burst_s) begin
      stop_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !active) begin
      flush_cnt_r <= `DQTX_FLUSH_SYMBOLS;
    end else if (state_r == ST_FLUSH && sym_end) begin
      flush_cnt_r <= flush_cnt_r - 3'h1;
    end
  end

  // The falling strobe edge is the cycle the counter reaches half a bit.
  always_ff @(posedge clk) begin
    if (reset) begin
      x_r <= 1'b0;
      y_r <= 1'b0;
    end else if (active && bit_cnt_r == `DQTX_HALF_CNT) begin
      if (bit_half_r) begin
        y_r <= data_s;
      end else begin
        x_r <= data_s;
      end
    end
  end

  // A three-deep dibit line cleared at burst start yields the zero run-in symbols.
  assign phase_nxt = phase_r + step_of(dly_r[`DQTX_ZERO_LINE-1]);
  always_ff @(posedge clk) begin
    if (reset || state_r == ST_START) begin
      phase_r <= 3'h0;
      for (int k = 0; k < `DQTX_ZERO_LINE; k++) begin
        dly_r[k] <= 2'b00;
      end
    end else if (sym_end) begin
      phase_r <= phase_nxt;
      dly_r[0] <= {x_r, y_r};
      for (int k = 1; k < `DQTX_ZERO_LINE; k++) begin
        dly_r[k] <= dly_r[k-1];
      end
    end
  end

  always_comb begin
    if (mode_s == DQTX_TONE_TEST) begin
      lvl_i = 10'sd0;
      lvl_q = `DQTX_AMP_FULL;
    end else begin
      lvl_i = cos_of(phase_nxt);
      lvl_q = cos_of(phase_nxt - 3'h2);
    end
  end

  // Linear steps over three symbols; the last step is clamped to full scale.
  assign gain = (gain_idx_r == `DQTX_RAMP_STEPS) ? `DQTX_GAIN_FULL
                : 9'(gain_idx_r * `DQTX_RAMP_STEP);
  always_ff @(posedge clk) begin
    if (reset || state_r == ST_START || !active) begin
      gain_idx_r <= 5'h00;
    end else if (sample_en) begin
      if (state_r == ST_RUN && gain_idx_r != `DQTX_RAMP_STEPS) begin
        gain_idx_r <= gain_idx_r + 5'h01;
      end else if (state_r == ST_FLUSH && gain_idx_r != 5'h00) begin
        gain_idx_r <= gain_idx_r - 5'h01;
      end
    end
  end

  dqtx_rrc_fir u_fir_i (
    .clk(clk),
    .reset(reset),
    .clear(state_r == ST_START),
    .push(sym_end),
    .level(lvl_i),
    .sample_en(sample_en),
    .phase({bit_half_r, bit_cnt_r[5:4]}),
    .gain(gain),
    .sample_r(fir_i)
  );
  dqtx_rrc_fir u_fir_q (
    .clk(clk),
    .reset(reset),
    .clear(state_r == ST_START),
    .push(sym_end),
    .level(lvl_q),
    .sample_en(sample_en),
    .phase({bit_half_r, bit_cnt_r[5:4]}),
    .gain(gain),
    .sample_r(fir_q)
  );

  // Word sync lands with the previous LSB, so the shift never pauses for it.
  always_ff @(posedge clk) begin
    if (reset || mode_s != DQTX_BYPASS) begin
      byp_on_r <= 1'b0;
      byp_cnt_r <= 4'h0;
      sreg_i_r <= 15'h0000;
      sreg_q_r <= 15'h0000;
      byp_i_r <= 10'h000;
      byp_q_r <= 10'h000;
    end else begin
      if (byp_on_r) begin
        sreg_i_r <= {sreg_i_r[13:0], data_s};
        sreg_q_r <= {sreg_q_r[13:0], burst_s};
        byp_cnt_r <= byp_cnt_r + 4'h1;
        if (byp_cnt_r == `DQTX_WORD_LAST) begin
          byp_i_r <= sreg_i_r[14:5];
          byp_q_r <= sreg_q_r[14:5];
        end
      end
      if (frame_s) begin
        byp_on_r <= 1'b1;
        byp_cnt_r <= 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      inphase_out <= 10'h000;
      quadrature_out <= 10'h000;
      out_enable <= 1'b0;
      ready_r <= 1'b0;
      burst_out_r <= 1'b0;
    end else begin
      out_enable <= state_r != ST_SLEEP;
      ready_r <= state_nxt == ST_IDLE;
      burst_out_r <= (state_r == ST_RUN) || (state_r == ST_FLUSH && gain_idx_r != 5'h00);
      if (state_r == ST_SLEEP || state_r == ST_CAL || mode_s == DQTX_FACTORY) begin
        inphase_out <= 10'h000;
        quadrature_out <= 10'h000;
      end else if (mode_s == DQTX_BYPASS) begin
        inphase_out <= byp_i_r;
        quadrature_out <= byp_q_r;
      end else begin
        inphase_out <= fir_i;
        quadrature_out <= fir_q;
      end
    end
  end
  assign link.ready = ready_r;
  assign link.burst_out = burst_out_r;
endmodule : dqtx_tx_port

// ### dqtx_defines.svh
// Timing counts, sizes and levels for the transmit port and its host.
`ifndef DQTX_DEFINES_SVH
`define DQTX_DEFINES_SVH
`define DQTX_MCLK_HZ 3110400
`define DQTX_BIT_HZ 48600
`define DQTX_BIT_DIV (`DQTX_MCLK_HZ / `DQTX_BIT_HZ)
`define DQTX_HALF_BIT (`DQTX_BIT_DIV / 2)
`define DQTX_BIT_LAST 6'h3f
`define DQTX_HALF_CNT 6'h20
`define DQTX_STROBE_DELAY 2'h3
`define DQTX_SAMPLE_LAST 4'hf
`define DQTX_RAMP_SYMBOLS 3
`define DQTX_SPS 8
`define DQTX_RAMP_STEPS 5'h18
`define DQTX_RAMP_STEP 9'h00b
`define DQTX_GAIN_FULL 9'h100
`define DQTX_FLUSH_SYMBOLS 3'h4
`define DQTX_CAL_CYCLES 10'h200
`define DQTX_ZERO_LINE 3
`define DQTX_AMP_FULL 10'h100
`define DQTX_AMP_DIAG 10'h0b5
`define DQTX_WORD_LAST 4'hf
`endif

// ### dqtx_pkg.sv
// Types shared by both ends of the transmit port link.
package dqtx_pkg;
  typedef enum logic [1:0] {
    DQTX_MODULATOR = 2'h0,
    DQTX_BYPASS = 2'h1,
    DQTX_TONE_TEST = 2'h2,
    DQTX_FACTORY = 2'h3
  } dqtx_mode_t;
  typedef enum logic [5:0] {
    ST_SLEEP = 6'h01,
    ST_CAL = 6'h02,
    ST_IDLE = 6'h04,
    ST_START = 6'h08,
    ST_RUN = 6'h10,
    ST_FLUSH = 6'h20
  } dqtx_state_t;
endpackage : dqtx_pkg

// ### dqtx_link_if.sv
// Pins between the transmit port and the data source.
`timescale 1ns/1ps
interface dqtx_link_if;
  logic power_req;
  logic mode_select_lo;
  logic mode_select_hi;
  logic burst_in;
  logic serial_tx_bits;
  logic ready;
  logic burst_out;
  logic dev_strobe_o;
  logic dev_strobe_oe;
  logic host_strobe_o;
  logic host_strobe_oe;
  logic bit_strobe;
  // The strobe pin is shared; nobody driving reads as low.
  assign bit_strobe = dev_strobe_oe ? dev_strobe_o : (host_strobe_oe ? host_strobe_o : 1'b0);
  modport dev (
    input power_req, mode_select_lo, mode_select_hi, burst_in, serial_tx_bits, bit_strobe,
    output ready, burst_out, dev_strobe_o, dev_strobe_oe
  );
  modport host (
    output power_req, mode_select_lo, mode_select_hi, burst_in, serial_tx_bits,
    output host_strobe_o, host_strobe_oe,
    input ready, burst_out, bit_strobe
  );
endinterface : dqtx_link_if

// ### dqtx_rrc_fir.sv
// Root-raised-cosine polyphase shaper with envelope gain, one channel.
`timescale 1ns/1ps
`include "dqtx_defines.svh"
module dqtx_rrc_fir
  import dqtx_pkg::*;
(
  input logic clk,
  input logic reset,
  input logic clear,
  input logic push,
  input logic signed [9:0] level,
  input logic sample_en,
  input logic [2:0] phase,
  input logic [8:0] gain,
  output logic signed [9:0] sample_r
);
  // Half of a symmetric response, eight samples per symbol, span of four symbols each side.
  localparam logic signed [9:0] TAP [0:32] = '{
    10'sd256, 10'sd248, 10'sd224, 10'sd187, 10'sd142, 10'sd94, 10'sd48, 10'sd10, -10'sd20,
    -10'sd38, -10'sd44, -10'sd41, -10'sd32, -10'sd19, -10'sd5, 10'sd6, 10'sd13, 10'sd18,
    10'sd18, 10'sd15, 10'sd10, 10'sd4, -10'sd1, -10'sd5, -10'sd7, -10'sd7, -10'sd6,
    -10'sd4, -10'sd2, 10'sd0, 10'sd1, 10'sd2, 10'sd2};
  logic signed [9:0] hist_r [0:8];
  logic signed [19:0] prod [0:8];
  logic signed [23:0] acc;
  logic signed [25:0] scaled;
  genvar j;
  generate
    for (j = 0; j < 9; j++) begin : g_tap
      logic signed [7:0] off;
      logic [6:0] mag;
      assign off = 8'(8 * j) - 8'sd32 - $signed({5'h0, phase});
      assign mag = off[7] ? 7'(-off) : off[6:0];
      assign prod[j] = (mag > 7'd32) ? 20'sd0 : hist_r[j] * TAP[mag[5:0]];
      always_ff @(posedge clk) begin
        if (reset || clear) begin
          hist_r[j] <= 10'sd0;
        end else if (push) begin
          hist_r[j] <= (j == 0) ? level : hist_r[(j == 0) ? 0 : j - 1];
        end
      end
    end
  endgenerate
  always_comb begin
    acc = 24'sd0;
    for (int k = 0; k < 9; k++) begin
      acc = acc + 24'(prod[k]);
    end
    scaled = 26'((acc >>> 8) * $signed({1'b0, gain})) >>> 8;
  end
  // Saturate rather than wrap so a hot symbol run never flips polarity.
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      sample_r <= 10'sd0;
    end else if (sample_en) begin
      if (scaled > 26'sd511) begin
        sample_r <= 10'sd511;
      end else if (scaled < -26'sd512) begin
        sample_r <= -10'sd512;
      end else begin
        sample_r <= scaled[9:0];
      end
    end
  end
endmodule : dqtx_rrc_fir

// ### dqtx_host_end.sv
// Data source end: drives power, mode, burst and serial data to the port.
`timescale 1ns/1ps
`include "dqtx_defines.svh"
module dqtx_host_end
  import dqtx_pkg::*;
(
  input logic clk,
  input logic reset,
  dqtx_link_if.host link,
  input logic power_on,
  input logic [1:0] mode_req,
  input logic burst_req,
  input logic tx_bit,
  output logic bit_take,
  input logic [15:0] i_word,
  input logic [15:0] q_word,
  output logic word_take,
  output logic dev_ready,
  output logic dev_burst_out
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic strobe_prev_r;
  dqtx_mode_t mode_r;
  logic burst_r;
  logic data_r;
  logic frame_r;
  logic [3:0] cnt_r;
  logic [15:0] cur_i_r;
  logic [15:0] cur_q_r;
  logic strobe_rise;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      strobe_prev_r <= 1'b0;
    end else begin
      meta_r <= {link.ready, link.burst_out, link.bit_strobe};
      sync_r <= meta_r;
      strobe_prev_r <= sync_r[0];
    end
  end
  assign dev_ready = sync_r[2];
  assign dev_burst_out = sync_r[1];
  assign strobe_rise = sync_r[0] && !strobe_prev_r;
  assign bit_take = (mode_r != DQTX_BYPASS) && strobe_rise;
  assign word_take = (mode_r == DQTX_BYPASS) && (cnt_r == `DQTX_WORD_LAST);

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r <= DQTX_MODULATOR;
      cnt_r <= 4'h0;
      frame_r <= 1'b0;
      burst_r <= 1'b0;
      data_r <= 1'b0;
      cur_i_r <= 16'h0000;
      cur_q_r <= 16'h0000;
    end else begin
      mode_r <= (mode_req == DQTX_FACTORY) ? DQTX_MODULATOR : dqtx_mode_t'(mode_req);
      if (mode_r == DQTX_BYPASS) begin
        cnt_r <= cnt_r + 4'h1;
        frame_r <= cnt_r == `DQTX_WORD_LAST;
        data_r <= cur_i_r[~cnt_r];
        burst_r <= cur_q_r[~cnt_r];
        if (cnt_r == `DQTX_WORD_LAST) begin
          cur_i_r <= i_word;
          cur_q_r <= q_word;
        end
      end else begin
        cnt_r <= 4'h0;
        frame_r <= 1'b0;
        if (!burst_r) begin
          burst_r <= burst_req && dev_ready;
        end else if (!burst_req) begin
          burst_r <= 1'b0;
        end
        if (strobe_rise) begin
          data_r <= tx_bit;
        end
      end
    end
  end
  assign link.power_req = power_on;
  assign link.mode_select_lo = mode_r[0];
  assign link.mode_select_hi = mode_r[1];
  assign link.burst_in = burst_r;
  assign link.serial_tx_bits = data_r;
  assign link.host_strobe_o = frame_r;
  assign link.host_strobe_oe = mode_r == DQTX_BYPASS;
endmodule : dqtx_host_end

// ### dqtx_link_chk.sv
// Concurrent checks on the link between the transmit port and its data source.
`timescale 1ns/1ps
module dqtx_link_chk (
  input logic clk,
  input logic reset,
  input logic power_req,
  input logic mode_select_lo,
  input logic mode_select_hi,
  input logic burst_in,
  input logic serial_tx_bits,
  input logic ready,
  input logic burst_out,
  input logic dev_strobe_o,
  input logic dev_strobe_oe,
  input logic host_strobe_o,
  input logic host_strobe_oe,
  input logic bit_strobe
);
  logic [5:0] high_len_r;
  logic [3:0] flush_rises_r;
  logic flushing_r;
  logic mod_path;
  assign mod_path = !mode_select_lo;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk) begin
    if (reset || !bit_strobe) begin
      high_len_r <= 6'h00;
    end else if (high_len_r != 6'h3f) begin
      high_len_r <= high_len_r + 6'h01;
    end
  end
  // Strobe rises are counted from the burst end; a bypass frame never opens a count.
  always_ff @(posedge clk) begin
    if (reset || ready) begin
      flushing_r <= 1'b0;
    end else if ($fell(burst_in) && mod_path) begin
      flushing_r <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset || $fell(burst_in)) begin
      flush_rises_r <= 4'h0;
    end else if ($rose(bit_strobe) && flush_rises_r != 4'hf) begin
      flush_rises_r <= flush_rises_r + 4'h1;
    end
  end
  a_sleep_quiet: assert property (!power_req [*4] |-> !ready && !dev_strobe_oe)
    else $error("port active while powered down");
  a_cal_ready: assert property ($rose(power_req) |-> ##[512:540] $rose(ready))
    else $error("ready not raised after calibration");
  a_ready_falls: assert property ($rose(burst_in) && ready && mod_path |-> ##[1:4] $fell(ready))
    else $error("ready did not drop at burst start");
  a_strobe_start: assert property ($fell(ready) && burst_in && mod_path |-> !bit_strobe [*2] ##[1:3] $rose(bit_strobe))
    else $error("strobe start delay wrong");
  a_strobe_half: assert property ($fell(bit_strobe) && dev_strobe_oe |-> high_len_r == 6'h20)
    else $error("strobe high phase not 32 cycles");
  a_strobe_quiet: assert property (ready && dev_strobe_oe |-> !bit_strobe)
    else $error("strobe running while ready");
  a_bypass_pins: assert property ((mode_select_lo && !mode_select_hi) [*4] |-> !dev_strobe_oe)
    else $error("strobe pin driven in bypass");
  a_flush_count: assert property ($rose(ready) && flushing_r |-> flush_rises_r inside {[4'h8:4'ha]})
    else $error("wrong number of flush strobes");
  a_burst_on: assert property ($fell(ready) && burst_in && mod_path |-> ##[1:400] burst_out)
    else $error("burst_out not raised during burst");
  a_burst_off: assert property ($rose(ready) |-> !burst_out)
    else $error("burst_out still high at ready");
  c_burst: cover property ($fell(ready) && burst_in);
  c_flush: cover property ($rose(ready) && flushing_r);
  c_bypass: cover property (host_strobe_oe && host_strobe_o);
endmodule : dqtx_link_chk

// ### dqtx_tx_port_tb.sv
// Self-checking bench joining the transmit port to its data source end.
`timescale 1ns/1ps
module dqtx_tx_port_tb;
  import dqtx_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic power_on = 1'b0;
  logic [1:0] mode_req = 2'h0;
  logic burst_req = 1'b0;
  logic tx_bit = 1'b0;
  logic [1:0] pat = 2'h0;
  logic bit_sel = 1'b0;
  logic last_bit = 1'b0;
  logic [15:0] i_word = 16'h0000;
  logic [15:0] q_word = 16'h0000;
  logic bit_take, word_take, dev_ready, dev_burst_out, out_enable;
  logic [9:0] inphase_out, quadrature_out;
  int err_total = 0;
  int samples_checked = 0;
  dqtx_link_if link ();
  always #2.5 clk = ~clk;
  dqtx_tx_port i_dqtx_tx_port (.clk(clk), .reset(reset), .link(link), .inphase_out(inphase_out),
    .quadrature_out(quadrature_out), .out_enable(out_enable));
  dqtx_host_end i_dqtx_host_end (.clk(clk), .reset(reset), .link(link), .power_on(power_on),
    .mode_req(mode_req), .burst_req(burst_req), .tx_bit(tx_bit), .bit_take(bit_take), .i_word(i_word),
    .q_word(q_word), .word_take(word_take), .dev_ready(dev_ready), .dev_burst_out(dev_burst_out));
  dqtx_link_chk i_dqtx_link_chk (.clk(clk), .reset(reset), .power_req(link.power_req),
    .mode_select_lo(link.mode_select_lo), .mode_select_hi(link.mode_select_hi), .burst_in(link.burst_in),
    .serial_tx_bits(link.serial_tx_bits), .ready(link.ready), .burst_out(link.burst_out),
    .dev_strobe_o(link.dev_strobe_o), .dev_strobe_oe(link.dev_strobe_oe), .host_strobe_o(link.host_strobe_o),
    .host_strobe_oe(link.host_strobe_oe), .bit_strobe(link.bit_strobe));
  task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
    samples_checked++;
    if (seen !== expected) begin
      err_total++;
      $display("mismatch at %0t: %s (seen %h, expected %h)", $time, what, seen, expected);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic timed_out();
    err_total++;
    $display("mismatch at %0t: wait ran out", $time);
    give_verdict();
  endtask : timed_out
  function automatic bit near(input int a, input int b);
    return (a - b) <= 3 && (b - a) <= 3;
  endfunction : near
  // The first bit taken after a burst starts is the X half of a dibit.
  always @(posedge clk) begin
    if (!burst_req) begin
      bit_sel <= 1'b0;
      tx_bit <= pat[1];
    end else if (bit_take) begin
      bit_sel <= ~bit_sel;
      tx_bit <= bit_sel ? pat[1] : pat[0];
    end
  end
  always @(posedge clk) begin
    last_bit <= link.serial_tx_bits;
    // Only judge while the port owns the strobe; a mode change leaves a stray bypass bit behind.
    if (!reset && mode_req == 2'h0 && link.dev_strobe_oe && link.serial_tx_bits !== last_bit) begin
      check(link.bit_strobe, 1'b1, "data moved while strobe low");
    end
  end
  task automatic power_up();
    int n;
    @(negedge clk);
    check(out_enable, 1'b0, "outputs driven in sleep");
    @(posedge clk);
    power_on <= 1'b1;
    n = 0;
    while (link.ready !== 1'b1 && n < 800) begin @(negedge clk); n++; end
    if (n == 800) timed_out();
    check(n >= 512, 1'b1, "ready before calibration time");
    check(out_enable, 1'b1, "outputs not driven when awake");
  endtask : power_up
  task automatic run_burst(input logic [1:0] m, input logic [1:0] d);
    int n;
    int sgn;
    logic signed [9:0] i1, q1, i2, q2;
    @(posedge clk);
    mode_req <= m;
    pat <= d;
    repeat (8) @(posedge clk);
    burst_req <= 1'b1;
    n = 0;
    while (link.burst_in !== 1'b1 && n < 8) begin @(negedge clk); n++; end
    if (n == 8) timed_out();
    n = 0;
    while (link.ready !== 1'b0 && n < 8) begin @(negedge clk); n++; end
    if (n == 8) timed_out();
    check(n, 3, "ready drop delay");
    n = 0;
    while (link.bit_strobe !== 1'b1 && n < 8) begin @(negedge clk); n++; end
    if (n == 8) timed_out();
    check(n, 3, "strobe start delay");
    repeat (2560) @(negedge clk);
    i1 = inphase_out;
    q1 = quadrature_out;
    repeat (256) @(negedge clk);
    i2 = inphase_out;
    q2 = quadrature_out;
    check(dev_burst_out, 1'b1, "burst_out low in burst");
    if (m == 2'h2) begin
      check(inphase_out, 10'h000, "tone I not zero");
      check(q2 > 0, 1'b1, "tone Q not full");
    end else begin
      check((i1 < 0 ? -i1 : i1) + (q1 < 0 ? -q1 : q1) > 50, 1'b1, "no signal");
      // Two steps of +pi/4 or -3pi/4 turn the vector by +pi/2, the other two by -pi/2.
      sgn = (d == 2'h0 || d == 2'h3) ? 1 : -1;
      check(near(i2, -sgn * q1) && near(q2, sgn * i1), 1'b1, "phase step wrong");
    end
    @(posedge clk);
    burst_req <= 1'b0;
    n = 0;
    while (link.ready !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
    if (n == 3000) timed_out();
    check(link.burst_out, 1'b0, "burst_out high after ramp");
    check(link.bit_strobe, 1'b0, "strobe left running");
  endtask : run_burst
  task automatic run_bypass();
    logic [15:0] words [4];
    int n;
    words = '{16'h8a7f, 16'h35c1, 16'h7fff, 16'h8000};
    for (int k = 0; k < 4; k += 2) begin
      @(posedge clk);
      mode_req <= 2'h1;
      i_word <= words[k];
      q_word <= words[k + 1];
      repeat (80) @(negedge clk);
      check(link.dev_strobe_oe, 1'b0, "port drives strobe pin");
      check(inphase_out, words[k][15:6], "I word");
      check(quadrature_out, words[k + 1][15:6], "Q word");
    end
    n = 0;
    while (word_take !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    if (n == 20) timed_out();
    n = 0;
    do begin @(negedge clk); n++; end while (word_take !== 1'b1 && n < 40);
    if (n == 40) timed_out();
    check(n, 16, "word period");
  endtask : run_bypass
  task automatic go_to_sleep();
    @(posedge clk);
    mode_req <= 2'h0;
    power_on <= 1'b0;
    repeat (6) @(negedge clk);
    check(out_enable, 1'b0, "outputs driven in sleep");
    check(link.ready, 1'b0, "ready high in sleep");
  endtask : go_to_sleep
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    power_up();
    for (int d = 0; d < 4; d++) run_burst(2'h0, d[1:0]);
    run_burst(2'h2, 2'h0);
    run_bypass();
    go_to_sleep();
    give_verdict();
  end
endmodule : dqtx_tx_port_tb
